// ===== adcc_pkg.sv
// Functional notes
// - conversion done sets sample ready flag
// - write one or sample read clears it
// - result or sequence done sets result flag
// - write one or result read clears it
// - busy while converting or settling pending
// - halted without run bit: finish, then stop
// - run bit set keeps converting while halted
// - no amplifier: sample duration plus half cycle
// - amplifier: duration plus one, amp length extra
// - continuous conversion restarts after each completed sequence
// - left justify bit shifts sample left, result too unless it is a plain sum
// - count code 0 none, 1..A powers two
// - result holds sum, or scaled sum in scaling variants, sample holds latest
// - differential bit: unsigned single or signed differential_select
// - mode decode: single, series, burst, scaling variants
// - immediate start returns to stop unless continuous
package adcc_pkg;

	localparam int ADDR_W   = 8;
	localparam int ADDR_LSB = 2;
	localparam int IDX_W    = ADDR_W - ADDR_LSB;

	// register indices, byte address is index times four
	localparam logic [IDX_W-1:0] IDX_FLAGS  = 6'h05;
	localparam logic [IDX_W-1:0] IDX_STATE  = 6'h06;
	localparam logic [IDX_W-1:0] IDX_HALT   = 6'h07;
	localparam logic [IDX_W-1:0] IDX_SAMPL  = 6'h08;
	localparam logic [IDX_W-1:0] IDX_RUNACC = 6'h09;
	localparam logic [IDX_W-1:0] IDX_CMD    = 6'h0A;
	localparam logic [IDX_W-1:0] IDX_AMP    = 6'h0B;
	localparam logic [IDX_W-1:0] IDX_RESULT = 6'h10;
	localparam logic [IDX_W-1:0] IDX_SAMPLE = 6'h12;

	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [7:0] RST_AMP   = 8'h04;
	localparam logic [7:0] MASK_HALT = 8'h01;
	localparam logic [7:0] MASK_RUN  = 8'h3F;
	localparam logic [7:0] MASK_CMD  = 8'hF7;

	localparam int BIT_RESULT_READY_FLAG  = 0;
	localparam int BIT_SAMPLE_READY_FLAG = 1;
	localparam int BIT_RUNHALT = 0;
	localparam int BIT_CONTINUOUS_CONVERSION = 5;
	localparam int BIT_LEFT_JUSTIFY = 4;
	localparam int BIT_DIFFERENTIAL_SELECT    = 7;
	localparam int BIT_AMPEN   = 0;

	localparam logic [2:0] START_STOP = 3'h0;
	localparam logic [2:0] START_IMM  = 3'h1;
	localparam logic [2:0] START_EVT  = 3'h4;

	localparam logic [2:0] MODE_SINGLE8  = 3'h0;
	localparam logic [2:0] MODE_SINGLE12 = 3'h1;
	localparam logic [2:0] MODE_SERIES   = 3'h2;
	localparam logic [2:0] MODE_SERIES_S = 3'h3;
	localparam logic [2:0] MODE_BURST    = 3'h4;
	localparam logic [2:0] MODE_BURST_S  = 3'h5;

	localparam logic [3:0] ACC_MAX_CODE = 4'hA;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// converter clock is the bus clock divided by two, so half a cycle is one edge
	localparam int CLK_PERIOD_NS      = 20;
	localparam int ADC_CLK_DIV        = 2;
	localparam int CONV_ADC_CYCLES_DF = 13;
	localparam int AMP_LEN_6          = 6;
	localparam int AMP_LEN_15         = 15;
	localparam int AMP_LEN_20         = 20;
	localparam int SETTLE_NS          = 1000;
	localparam int SETTLE_CYC         = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic {PH_IDLE, PH_CONV} adcc_phase_type;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic [2:0]        awprot;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic [2:0]        arprot;
		logic              rready;
	} adcc_axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} adcc_axi_rsp_type;

endpackage

// ===== adcc_timer.sv
module adcc_timer #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	input  wire logic         abort,
	output logic              expired,
	output logic              running
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} adcc_tmr_state_type;

	adcc_tmr_state_type st_q;
	adcc_tmr_state_type st_d;

	if (W < 2) begin : g_chk
		$error("timer width too small");
	end

	always_comb begin
		st_d = st_q;
		if (load) begin
			st_d.cnt = loadVal;
		end else if (abort) begin
			st_d.cnt = '0;
		end else if (st_q.cnt != '0) begin
			st_d.cnt = st_q.cnt - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// expiry on the last counted edge; abort suppresses it
	assign expired = (st_q.cnt == W'(1)) && !abort;
	assign running = (st_q.cnt != '0);

endmodule // adcc_timer

// ===== adcc_core.sv
module adcc_core #(
	parameter int CONV_ADC_CYCLES = adcc_pkg::CONV_ADC_CYCLES_DF,
	parameter int SETTLE_CYCLES   = adcc_pkg::SETTLE_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire adcc_pkg::adcc_axi_req_type axiReq,
	output adcc_pkg::adcc_axi_rsp_type    axiRsp,
	input  wire logic                     cpuHalted,
	input  wire logic                     evtTrigger,
	input  wire logic [11:0]              posCode,
	input  wire logic [11:0]              negCode,
	output logic                          converterBusy
);

	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255 || CONV_ADC_CYCLES < 1 || CONV_ADC_CYCLES > 64) begin : g_chk
		$error("timing parameter out of range");
	end

	// unamplified conversion at zero duration, in bus clock edges
	localparam int CONV_LEN_D0 = 2 * CONV_ADC_CYCLES + 1;

	typedef struct packed {
		adcc_pkg::adcc_phase_type phase;
		logic [7:0]               haltCtl;
		logic [7:0]               dur;
		logic [7:0]               runAcc;
		logic [7:0]               cmd;
		logic [7:0]               ampCtl;
		logic                     sample_ready_flag;
		logic                     result_ready_flag;
		logic [15:0]              sample;
		logic [15:0]              result;
		logic [21:0]              acc;
		logic [10:0]              accCnt;
		logic                     inSeq;
		logic                     immPend;
		logic                     frPend;
		logic [7:0]               settle;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [31:0]              rdata;
		logic [1:0]               rresp;
	} adcc_core_state_type;

	adcc_core_state_type st_q;
	adcc_core_state_type st_d;

	logic                            wrTake;
	logic                            rdTake;
	logic [adcc_pkg::IDX_W-1:0]      wIdx;
	logic [adcc_pkg::IDX_W-1:0]      rIdx;
	logic [7:0]                      wByte;
	logic                            wLane;
	logic                            haltStop;
	logic [2:0]                      mode;
	logic [2:0]                      start;
	logic                            differential_select;
	logic                            isSingle;
	logic                            isBurst;
	logic                            isScale;
	logic [3:0]                      accShift;
	logic [10:0]                     needed;
	logic [12:0]                     diff13;
	logic [11:0]                     raw;
	logic [21:0]                     rawExt;
	logic [21:0]                     accSum;
	logic [21:0]                     scaled;
	logic [15:0]                     sampleVal;
	logic [15:0]                     resultVal;
	logic [15:0]                     ampLen;
	logic [15:0]                     convLen;
	logic                            newTrig;
	logic                            burstNext;
	logic                            launch;
	logic                            tmrExp;
	logic                            tmrRun;
	logic                            stopWr;
	logic                            resSet;
	logic                            resClr;
	logic                            sampClr;
	logic                            seqDone;

	// fits a 12-bit value into 16 bits, left adjusted on request
	function automatic logic [15:0] fit16(input logic [11:0] v, input logic is8, input logic sgn,
	                                      input logic la);
		logic [15:0] r;
		r = sgn ? {{4{v[11]}}, v} : {4'h0, v};
		if (la) begin
			r = is8 ? {v[7:0], 8'h00} : {v, 4'h0};
		end
		return r;
	endfunction

	assign wrTake   = axiReq.awvalid && axiReq.wvalid && !st_q.bvalid;
	assign rdTake   = axiReq.arvalid && !st_q.rvalid;
	assign wIdx     = axiReq.awaddr[adcc_pkg::ADDR_W-1:adcc_pkg::ADDR_LSB];
	assign rIdx     = axiReq.araddr[adcc_pkg::ADDR_W-1:adcc_pkg::ADDR_LSB];
	assign wByte    = axiReq.wdata[7:0];
	assign wLane    = axiReq.wstrb[0];

	assign haltStop = cpuHalted && !st_q.haltCtl[adcc_pkg::BIT_RUNHALT];
	assign mode     = st_q.cmd[6:4];
	assign start    = st_q.cmd[2:0];
	assign differential_select     = st_q.cmd[adcc_pkg::BIT_DIFFERENTIAL_SELECT];
	// reserved mode codes behave as single conversions
	assign isBurst  = (mode == adcc_pkg::MODE_BURST) || (mode == adcc_pkg::MODE_BURST_S);
	assign isSingle = !isBurst && (mode != adcc_pkg::MODE_SERIES) && (mode != adcc_pkg::MODE_SERIES_S);
	assign isScale  = (mode == adcc_pkg::MODE_SERIES_S) || (mode == adcc_pkg::MODE_BURST_S);
	// reserved count codes fall back to no accumulation
	assign accShift = (isSingle || st_q.runAcc[3:0] > adcc_pkg::ACC_MAX_CODE) ? 4'h0 : st_q.runAcc[3:0];
	assign needed   = 11'(1) << accShift;

	assign diff13   = {1'b0, posCode} - {1'b0, negCode};
	always_comb begin
		raw = differential_select ? diff13[12:1] : posCode;
		if (mode == adcc_pkg::MODE_SINGLE8) begin
			raw = differential_select ? {{4{raw[11]}}, raw[11:4]} : {4'h0, raw[11:4]};
		end
	end
	assign rawExt    = differential_select ? {{10{raw[11]}}, raw} : {10'h000, raw};
	assign accSum    = st_q.acc + rawExt;
	assign scaled    = differential_select ? 22'($signed(accSum) >>> accShift) : (accSum >> accShift);
	assign sampleVal = fit16(raw, mode == adcc_pkg::MODE_SINGLE8, differential_select, st_q.runAcc[adcc_pkg::BIT_LEFT_JUSTIFY]);
	// a plain sum can exceed 12 bits, so it is never left adjusted
	assign resultVal = (isScale || accShift == 4'h0) ?
	                   fit16(scaled[11:0], mode == adcc_pkg::MODE_SINGLE8, differential_select, st_q.runAcc[adcc_pkg::BIT_LEFT_JUSTIFY]) :
	                   accSum[15:0];

	always_comb begin
		unique case (st_q.ampCtl[2:1])
			2'h0:    ampLen = 16'(adcc_pkg::AMP_LEN_6);
			2'h1:    ampLen = 16'(adcc_pkg::AMP_LEN_15);
			default: ampLen = 16'(adcc_pkg::AMP_LEN_20);
		endcase
	end

	always_comb begin
		if (st_q.ampCtl[adcc_pkg::BIT_AMPEN]) begin
			convLen = 16'((st_q.dur + 16'(1)) * adcc_pkg::ADC_CLK_DIV) + 16'(ampLen * adcc_pkg::ADC_CLK_DIV);
		end else begin
			convLen = 16'(st_q.dur * adcc_pkg::ADC_CLK_DIV) + 16'(1);
		end
		convLen = convLen + 16'(CONV_ADC_CYCLES * adcc_pkg::ADC_CLK_DIV);
	end

	// halt only blocks new triggers; a burst already running carries on
	assign newTrig = ((start == adcc_pkg::START_IMM && st_q.immPend) ||
	                  (start == adcc_pkg::START_EVT && evtTrigger) ||
	                  (st_q.frPend && start != adcc_pkg::START_STOP)) &&
	                 !haltStop && st_q.settle == 8'h00 && st_q.phase == adcc_pkg::PH_IDLE &&
	                 !(st_q.inSeq && isBurst);
	assign burstNext = st_q.phase == adcc_pkg::PH_IDLE && st_q.inSeq && isBurst && st_q.settle == 8'h00;
	// a stop in the launch cycle wins, or the timer would run on with nothing to report
	assign launch    = (newTrig || burstNext) && !stopWr;
	assign stopWr    = wrTake && wLane && wIdx == adcc_pkg::IDX_CMD && wByte[2:0] == adcc_pkg::START_STOP;
	assign seqDone   = tmrExp && (st_q.accCnt + 11'(1) >= needed);
	assign resSet    = seqDone;
	assign resClr    = (wrTake && wLane && wIdx == adcc_pkg::IDX_FLAGS && wByte[adcc_pkg::BIT_RESULT_READY_FLAG]) ||
	                   (rdTake && rIdx == adcc_pkg::IDX_RESULT);
	assign sampClr   = (wrTake && wLane && wIdx == adcc_pkg::IDX_FLAGS && wByte[adcc_pkg::BIT_SAMPLE_READY_FLAG]) ||
	                   (rdTake && rIdx == adcc_pkg::IDX_SAMPLE);

	adcc_timer #(
		.W (16)
	) u_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.load    (launch),
		.loadVal (convLen),
		.abort   (stopWr),
		.expired (tmrExp),
		.running (tmrRun)
	);

	always_comb begin
		st_d = st_q;
		if (st_q.settle != 8'h00) begin
			st_d.settle = st_q.settle - 8'h01;
		end
		// clears first, so a set in the same cycle wins
		if (sampClr) begin
			st_d.sample_ready_flag = 1'b0;
		end
		if (resClr) begin
			st_d.result_ready_flag = 1'b0;
		end
		if (launch) begin
			st_d.phase   = adcc_pkg::PH_CONV;
			st_d.inSeq   = 1'b1;
			st_d.frPend  = 1'b0;
			if (newTrig && start == adcc_pkg::START_IMM) begin
				st_d.immPend = 1'b0;
			end
		end
		if (tmrExp) begin
			st_d.phase   = adcc_pkg::PH_IDLE;
			st_d.sample  = sampleVal;
			st_d.sample_ready_flag = 1'b1;
			st_d.acc     = accSum;
			st_d.accCnt  = st_q.accCnt + 11'(1);
			if (seqDone) begin
				st_d.result = resultVal;
				st_d.result_ready_flag = 1'b1;
				st_d.acc    = '0;
				st_d.accCnt = '0;
				st_d.inSeq  = 1'b0;
				if (st_q.runAcc[adcc_pkg::BIT_CONTINUOUS_CONVERSION]) begin
					st_d.frPend = 1'b1;
				end else if (start == adcc_pkg::START_IMM) begin
					st_d.cmd[2:0] = adcc_pkg::START_STOP;
				end
			end
		end
		if (wrTake) begin
			st_d.bvalid = 1'b1;
			st_d.bresp  = adcc_pkg::RESP_OKAY;
			unique case (wIdx)
				adcc_pkg::IDX_FLAGS, adcc_pkg::IDX_STATE, adcc_pkg::IDX_RESULT, adcc_pkg::IDX_SAMPLE: begin
				end
				adcc_pkg::IDX_HALT: begin
					if (wLane) st_d.haltCtl = wByte & adcc_pkg::MASK_HALT;
				end
				adcc_pkg::IDX_SAMPL: begin
					if (wLane) begin
						st_d.dur    = wByte;
						st_d.settle = 8'(SETTLE_CYCLES);
					end
				end
				adcc_pkg::IDX_RUNACC: begin
					if (wLane) begin
						st_d.runAcc = wByte & adcc_pkg::MASK_RUN;
						st_d.settle = 8'(SETTLE_CYCLES);
					end
				end
				adcc_pkg::IDX_AMP: begin
					if (wLane) begin
						st_d.ampCtl = wByte;
						st_d.settle = 8'(SETTLE_CYCLES);
					end
				end
				adcc_pkg::IDX_CMD: begin
					if (wLane) begin
						st_d.cmd = wByte & adcc_pkg::MASK_CMD;
						if (wByte[7:4] != st_q.cmd[7:4]) begin
							st_d.settle = 8'(SETTLE_CYCLES);
						end
						// leaving accumulation drops the partial sum
						if (wByte[6:5] == 2'b00 && !isSingle) begin
							st_d.acc    = '0;
							st_d.accCnt = '0;
							st_d.inSeq  = 1'b0;
						end
						if (wByte[2:0] == adcc_pkg::START_IMM) begin
							st_d.immPend = 1'b1;
						end
						if (wByte[2:0] == adcc_pkg::START_STOP) begin
							st_d.phase   = adcc_pkg::PH_IDLE;
							st_d.acc     = '0;
							st_d.accCnt  = '0;
							st_d.inSeq   = 1'b0;
							st_d.immPend = 1'b0;
							st_d.frPend  = 1'b0;
						end
					end
				end
				default: st_d.bresp = adcc_pkg::RESP_SLVERR;
			endcase
		end else if (axiReq.bready) begin
			st_d.bvalid = 1'b0;
		end
		if (rdTake) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = adcc_pkg::RESP_OKAY;
			st_d.rdata  = '0;
			unique case (rIdx)
				adcc_pkg::IDX_FLAGS:  st_d.rdata[1:0] = {st_q.sample_ready_flag, st_q.result_ready_flag};
				adcc_pkg::IDX_STATE:  st_d.rdata[0]   = converterBusy;
				adcc_pkg::IDX_HALT:   st_d.rdata[7:0] = st_q.haltCtl;
				adcc_pkg::IDX_SAMPL:  st_d.rdata[7:0] = st_q.dur;
				adcc_pkg::IDX_RUNACC: st_d.rdata[7:0] = st_q.runAcc;
				adcc_pkg::IDX_CMD:    st_d.rdata[7:0] = st_q.cmd;
				adcc_pkg::IDX_AMP:    st_d.rdata[7:0] = st_q.ampCtl;
				adcc_pkg::IDX_RESULT: st_d.rdata[15:0] = st_q.result;
				adcc_pkg::IDX_SAMPLE: st_d.rdata[15:0] = st_q.sample;
				default:              st_d.rresp = adcc_pkg::RESP_SLVERR;
			endcase
		end else if (axiReq.rready) begin
			st_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q        <= '0;
			st_q.phase  <= adcc_pkg::PH_IDLE;
			st_q.ampCtl <= adcc_pkg::RST_AMP;
		end else begin
			st_q <= st_d;
		end
	end

	assign converterBusy = st_q.phase == adcc_pkg::PH_CONV || (st_q.inSeq && isBurst) ||
	                       st_q.settle != 8'h00;
	assign axiRsp.awready = wrTake;
	assign axiRsp.wready  = wrTake;
	assign axiRsp.bvalid  = st_q.bvalid;
	assign axiRsp.bresp   = st_q.bresp;
	assign axiRsp.arready = !st_q.rvalid;
	assign axiRsp.rvalid  = st_q.rvalid;
	assign axiRsp.rdata   = st_q.rdata;
	assign axiRsp.rresp   = st_q.rresp;

	a_samp_set: assert property (@(posedge clk) disable iff (!rst_n) tmrExp |=> st_q.sample_ready_flag)
		else $error("sample flag not set after conversion");
	a_samp_rdclr: assert property (@(posedge clk) disable iff (!rst_n)
		(rdTake && rIdx == adcc_pkg::IDX_SAMPLE && !tmrExp) |=> !st_q.sample_ready_flag)
		else $error("sample read did not clear flag");
	a_res_set: assert property (@(posedge clk) disable iff (!rst_n)
		seqDone |=> st_q.result_ready_flag && st_q.result == $past(resultVal))
		else $error("result flag or value wrong");
	a_res_w1c: assert property (@(posedge clk) disable iff (!rst_n)
		(wrTake && wLane && wIdx == adcc_pkg::IDX_FLAGS && !resSet) |=>
		st_q.result_ready_flag == ($past(st_q.result_ready_flag) && !$past(wByte[adcc_pkg::BIT_RESULT_READY_FLAG])))
		else $error("result flag write one clear wrong");
	a_busy_conv: assert property (@(posedge clk) disable iff (!rst_n)
		(tmrRun || st_q.settle != 8'h00) |-> converterBusy)
		else $error("busy low during activity");
	a_halt_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(haltStop && !st_q.inSeq && st_q.phase == adcc_pkg::PH_IDLE) |=> st_q.phase == adcc_pkg::PH_IDLE)
		else $error("conversion started while halted");
	a_conv_len: assert property (@(posedge clk) disable iff (!rst_n)
		(launch && !stopWr && !st_q.ampCtl[adcc_pkg::BIT_AMPEN] && st_q.dur == 8'h00) |->
		##CONV_LEN_D0 (tmrExp || stopWr || start == adcc_pkg::START_STOP))
		else $error("unamplified conversion length wrong");
	a_imm_stop: assert property (@(posedge clk) disable iff (!rst_n)
		(seqDone && start == adcc_pkg::START_IMM && !st_q.runAcc[adcc_pkg::BIT_CONTINUOUS_CONVERSION] && !wrTake) |=>
		st_q.cmd[2:0] == adcc_pkg::START_STOP)
		else $error("immediate start not returned to stop");
	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		(resSet && resClr) |=> st_q.result_ready_flag)
		else $error("flag event lost to clear");
	a_burst_count: assert property (@(posedge clk) disable iff (!rst_n)
		(seqDone && isBurst) |-> (st_q.accCnt + 11'(1) == needed))
		else $error("burst sequence length wrong");

endmodule // adcc_core

// ===== test_adc_control_status_regs.sv
module test_adc_control_status_regs;
	timeunit 1ns;
	timeprecision 1ps;

	// short conversion and settle counts keep the run brief; only differences are checked
	localparam int CONV = 2;

	logic                       clk;
	logic                       rst_n;
	adcc_pkg::adcc_axi_req_type axiReq;
	adcc_pkg::adcc_axi_rsp_type axiRsp;
	logic                       cpuHalted;
	logic                       evtTrigger;
	logic [11:0]                posCode;
	logic [11:0]                negCode;
	logic                       converterBusy;
	int                         failCount;
	int                         checked;
	logic [1:0]                 resp;
	logic [31:0]                data;
	int                         n;
	int                         m0;
	int                         m1;
	int                         m2;
	logic [7:0]                 accCode [4] = '{8'h02, 8'h02, 8'h0B, 8'h01};
	logic [7:0]                 accCmd  [4] = '{8'h41, 8'h51, 8'h41, 8'h41};
	logic [31:0]                accExp  [4] = '{32'h2AF0, 32'h0ABC, 32'h0ABC, 32'h1578};
	logic [5:0]                 rIdx    [7] = '{adcc_pkg::IDX_FLAGS, adcc_pkg::IDX_STATE, adcc_pkg::IDX_HALT,
		adcc_pkg::IDX_SAMPL, adcc_pkg::IDX_RUNACC, adcc_pkg::IDX_CMD, adcc_pkg::IDX_AMP};

	adcc_core #(.CONV_ADC_CYCLES(CONV), .SETTLE_CYCLES(2)) DUT (
		.clk          (clk),
		.rst_n        (rst_n),
		.axiReq       (axiReq),
		.axiRsp       (axiRsp),
		.cpuHalted    (cpuHalted),
		.evtTrigger   (evtTrigger),
		.posCode      (posCode),
		.negCode      (negCode),
		.converterBusy(converterBusy)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// bready and rready stay high, so each response is taken on the edge it is seen
	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		int k;
		logic aw;
		logic w;
		k = 0;
		aw = 1'b0;
		w = 1'b0;
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr  <= {idx, 2'b00};
		axiReq.wvalid  <= 1'b1;
		axiReq.wdata   <= d;
		axiReq.wstrb   <= 4'hF;
		do begin
			@(posedge clk);
			k++;
			if (!aw && axiRsp.awready === 1'b1) begin
				aw = 1'b1;
				axiReq.awvalid <= 1'b0;
			end
			if (!w && axiRsp.wready === 1'b1) begin
				w = 1'b1;
				axiReq.wvalid <= 1'b0;
			end
		end while (!(aw && w) && k < 100);
		while (axiRsp.bvalid !== 1'b1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		resp = axiRsp.bresp;
		if (k >= 100) begin
			failCount++;
			$display("wrong value at %0t: write timed out", $time);
		end
	endtask

	task automatic rd(input logic [5:0] idx);
		int k;
		k = 0;
		axiReq.arvalid <= 1'b1;
		axiReq.araddr  <= {idx, 2'b00};
		do begin
			@(posedge clk);
			k++;
		end while (axiRsp.arready !== 1'b1 && k < 100);
		axiReq.arvalid <= 1'b0;
		do begin
			@(posedge clk);
			k++;
		end while (axiRsp.rvalid !== 1'b1 && k < 100);
		data = axiRsp.rdata;
		resp = axiRsp.rresp;
		if (k >= 100) begin
			failCount++;
			$display("wrong value at %0t: read timed out", $time);
		end
	endtask

	task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
		rd(idx);
		chk(data, exp);
	endtask

	// counts busy cycles; ends after four quiet cycles so a gap before launch is not taken as the end
	task automatic busyLen(output int cnt);
		int low;
		int k;
		cnt = 0;
		low = 0;
		k = 0;
		while (low < 4 && k < 5000) begin
			@(posedge clk);
			k++;
			if (converterBusy === 1'b1) begin
				cnt++;
				low = 0;
			end else begin
				low++;
			end
		end
		if (k >= 5000) begin
			failCount++;
			$display("wrong value at %0t: busy never ended", $time);
		end
	endtask

	task automatic cfg(input logic [5:0] idx, input logic [31:0] d);
		wr(idx, d);
		busyLen(n);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		$display("wrong value at %0t: run did not finish", $time);
		end_sim();
	end

	initial begin
		rst_n = 1'b0;
		axiReq = '0;
		axiReq.bready = 1'b1;
		axiReq.rready = 1'b1;
		cpuHalted = 1'b0;
		evtTrigger = 1'b0;
		posCode = 12'hABC;
		negCode = 12'h000;
		failCount = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdc(rIdx[i], (i == 6) ? 32'h04 : 32'h00);
		end
		rd(6'h3F);
		chk(data, 32'h0);
		chk({30'h0, resp}, {30'h0, adcc_pkg::RESP_SLVERR});
		wr(6'h3F, 32'h0);
		chk({30'h0, resp}, {30'h0, adcc_pkg::RESP_SLVERR});
		wr(adcc_pkg::IDX_HALT, 32'hFF);
		chk({30'h0, resp}, {30'h0, adcc_pkg::RESP_OKAY});
		rdc(adcc_pkg::IDX_HALT, 32'h01);
		wr(adcc_pkg::IDX_HALT, 32'h00);
		cfg(adcc_pkg::IDX_CMD, 32'h11);
		rdc(adcc_pkg::IDX_FLAGS, 32'h03);
		rdc(adcc_pkg::IDX_CMD, 32'h10);
		rdc(adcc_pkg::IDX_SAMPLE, 32'h0ABC);
		rdc(adcc_pkg::IDX_FLAGS, 32'h01);
		wr(adcc_pkg::IDX_FLAGS, 32'h00);
		rdc(adcc_pkg::IDX_FLAGS, 32'h01);
		rdc(adcc_pkg::IDX_RESULT, 32'h0ABC);
		rdc(adcc_pkg::IDX_FLAGS, 32'h00);
		cfg(adcc_pkg::IDX_CMD, 32'h11);
		wr(adcc_pkg::IDX_FLAGS, 32'h01);
		rdc(adcc_pkg::IDX_FLAGS, 32'h02);
		wr(adcc_pkg::IDX_FLAGS, 32'h00);
		rdc(adcc_pkg::IDX_FLAGS, 32'h02);
		wr(adcc_pkg::IDX_FLAGS, 32'h02);
		rdc(adcc_pkg::IDX_FLAGS, 32'h00);
		cfg(adcc_pkg::IDX_RUNACC, 32'h10);
		cfg(adcc_pkg::IDX_CMD, 32'h11);
		rdc(adcc_pkg::IDX_RESULT, 32'hABC0);
		cfg(adcc_pkg::IDX_CMD, 32'h01);
		rdc(adcc_pkg::IDX_RESULT, 32'hAB00);
		cfg(adcc_pkg::IDX_RUNACC, 32'h00);
		posCode <= 12'h800;
		negCode <= 12'h400;
		cfg(adcc_pkg::IDX_CMD, 32'h91);
		rdc(adcc_pkg::IDX_RESULT, 32'h0200);
		posCode <= 12'hABC;
		for (int i = 0; i < 4; i++) begin
			cfg(adcc_pkg::IDX_RUNACC, {24'h0, accCode[i]});
			cfg(adcc_pkg::IDX_CMD, {24'h0, accCmd[i]});
			rdc(adcc_pkg::IDX_RESULT, accExp[i]);
			rdc(adcc_pkg::IDX_SAMPLE, 32'h0ABC);
		end
		cfg(adcc_pkg::IDX_RUNACC, 32'h01);
		cfg(adcc_pkg::IDX_CMD, 32'h21);
		rdc(adcc_pkg::IDX_FLAGS, 32'h02);
		cfg(adcc_pkg::IDX_CMD, 32'h21);
		rdc(adcc_pkg::IDX_RESULT, 32'h1578);
		cfg(adcc_pkg::IDX_RUNACC, 32'h00);
		cfg(adcc_pkg::IDX_CMD, 32'h10);
		cfg(adcc_pkg::IDX_CMD, 32'h11);
		m0 = n;
		cfg(adcc_pkg::IDX_SAMPL, 32'h03);
		cfg(adcc_pkg::IDX_CMD, 32'h11);
		m1 = n;
		cfg(adcc_pkg::IDX_AMP, 32'h01);
		cfg(adcc_pkg::IDX_CMD, 32'h11);
		m2 = n;
		chk(32'(m1 - m0), 32'h6);
		chk(32'(m2 - m1), 32'hD);
		cfg(adcc_pkg::IDX_AMP, 32'h04);
		cfg(adcc_pkg::IDX_SAMPL, 32'hFF);
		wr(adcc_pkg::IDX_CMD, 32'h11);
		rdc(adcc_pkg::IDX_STATE, 32'h01);
		busyLen(n);
		rdc(adcc_pkg::IDX_STATE, 32'h00);
		cfg(adcc_pkg::IDX_SAMPL, 32'h00);
		wr(adcc_pkg::IDX_FLAGS, 32'h03);
		cpuHalted <= 1'b1;
		cfg(adcc_pkg::IDX_CMD, 32'h11);
		chk(32'(n), 32'h0);
		rdc(adcc_pkg::IDX_FLAGS, 32'h00);
		cfg(adcc_pkg::IDX_HALT, 32'h01);
		rdc(adcc_pkg::IDX_FLAGS, 32'h03);
		cpuHalted <= 1'b0;
		wr(adcc_pkg::IDX_HALT, 32'h00);
		wr(adcc_pkg::IDX_FLAGS, 32'h03);
		wr(adcc_pkg::IDX_CMD, 32'h14);
		evtTrigger <= 1'b1;
		@(posedge clk);
		evtTrigger <= 1'b0;
		// the clear is taken on the completion edge of a 2*CONV+1 cycle conversion
		repeat (2 * CONV) @(posedge clk);
		wr(adcc_pkg::IDX_FLAGS, 32'h03);
		rdc(adcc_pkg::IDX_FLAGS, 32'h03);
		// single mode only: continuous with series or burst is not exercised here
		cfg(adcc_pkg::IDX_RUNACC, 32'h20);
		wr(adcc_pkg::IDX_CMD, 32'h11);
		repeat (30) @(posedge clk);
		rdc(adcc_pkg::IDX_CMD, 32'h11);
		wr(adcc_pkg::IDX_FLAGS, 32'h03);
		repeat (20) @(posedge clk);
		rdc(adcc_pkg::IDX_FLAGS, 32'h03);
		cfg(adcc_pkg::IDX_CMD, 32'h10);
		cfg(adcc_pkg::IDX_RUNACC, 32'h00);
		end_sim();
	end

endmodule // test_adc_control_status_regs
